// ===== rtl/fci_regs.sv
`timescale 1ns/10ps
`default_nettype none
module fci_regs (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // sequencer side
    input wire fci_pkg::fci_seq_t seq_i,
    output logic command_lock_flag_o,
    output logic setup_init_o,
    output logic [31:0] command_start_address_o,
    output logic [31:0] command_end_address_o,
    output logic [31:0] target_start_address_o,
    output logic [31:0] target_end_address_o,
    // work ram gating
    output logic work_ram_access_enable_o,
    output logic work_ram_transfer_mode_o,
    output logic work_ram_read_allow_o,
    output logic work_ram_write_allow_o,
    // interrupt requests
    output logic flash_error_irq_o,
    output logic ready_irq_o
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [31:0] adr, input logic [31:0] ofs);
        hit = (adr[31:2] == ofs[31:2]);
    endfunction

    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        lane_merge = r;
    endfunction

    // area and boundary masking of the start address per command
    function automatic logic [31:0] eff_start(input logic [31:0] a, input fci_pkg::fci_cmd_t k,
                                              input logic big);
        logic [31:0] area;
        logic [31:0] low;
        area = fci_pkg::CODE_AREA_MASK;
        low = fci_pkg::BND_4;
        case (k)
            fci_pkg::CMD_PROG_CODE: low = fci_pkg::BND_256;
            fci_pkg::CMD_PROG_DATA:
            begin
                area = fci_pkg::DATA_AREA_MASK;
                low = fci_pkg::BND_4;
            end
            fci_pkg::CMD_ERASE_CODE: low = big ? fci_pkg::BND_32K : fci_pkg::BND_8K;
            fci_pkg::CMD_ERASE_DATA:
            begin
                area = fci_pkg::DATA_AREA_MASK;
                low = fci_pkg::BND_64;
            end
            fci_pkg::CMD_BLANK:
            begin
                area = fci_pkg::DATA_AREA_MASK;
                low = fci_pkg::BND_4;
            end
            fci_pkg::CMD_CONFIG:
            begin
                area = fci_pkg::DATA_AREA_MASK;
                low = fci_pkg::BND_16;
            end
            fci_pkg::CMD_LOCKBIT: low = big ? fci_pkg::BND_32K : fci_pkg::BND_8K;
            default:
            begin
                area = fci_pkg::CODE_AREA_MASK;
                low = fci_pkg::BND_4;
            end
        endcase
        eff_start = a & area & ~low;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    fci_pkg::fci_state_t s_q;
    fci_pkg::fci_state_t s_d;

    logic req;
    logic wr_now;
    logic init_wr;
    logic viol;
    logic [31:0] bc_start;
    logic [31:0] bc_end;
    logic bc_bad;
    logic [7:0] err_flags;

    assign req = wb_cyc_i & wb_stb_i;
    // writes land on the edge where the master sees ack
    assign wr_now = req & wb_we_i & s_q.ack;
    assign init_wr = wr_now & hit(wb_adr_i, fci_pkg::OFS_SETUP) & wb_sel_i[0]
                     & wb_dat_i[fci_pkg::BIT_SETUP_INIT];
    assign viol = seq_i.data_violation_flag | seq_i.code_violation_flag;
    assign bc_start = eff_start(s_q.start_addr, fci_pkg::CMD_BLANK, 1'b0);
    assign bc_end = s_q.end_addr & fci_pkg::DATA_AREA_MASK & ~fci_pkg::BND_4;
    assign bc_bad = seq_i.blank_check_direction ? !(bc_start > bc_end) : !(bc_start < bc_end);

    always_comb
    begin
        err_flags = 8'h00;
        err_flags[fci_pkg::BIT_CORRECTED] = seq_i.corrected_error_flag;
        err_flags[fci_pkg::BIT_DATA_VIOL] = seq_i.data_violation_flag;
        err_flags[fci_pkg::BIT_LOCK] = s_q.lock;
        err_flags[fci_pkg::BIT_CODE_VIOL] = seq_i.code_violation_flag;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        // single-cycle ack, one cycle after the request appears
        s_d.ack = req & ~s_q.ack;
        if (req & ~s_q.ack)
        begin
            s_d.rdata = 32'h00000000;
            if (hit(wb_adr_i, fci_pkg::OFS_ERR_EN))
            begin
                s_d.rdata[7:0] = s_q.err_en;
            end
            else if (hit(wb_adr_i, fci_pkg::OFS_RDY_EN))
            begin
                s_d.rdata[fci_pkg::BIT_RDY_EN] = s_q.rdy_en;
            end
            else if (hit(wb_adr_i, fci_pkg::OFS_START))
            begin
                s_d.rdata = s_q.start_addr;
            end
            else if (hit(wb_adr_i, fci_pkg::OFS_END))
            begin
                s_d.rdata = s_q.end_addr;
            end
            else if (hit(wb_adr_i, fci_pkg::OFS_RAM_EN))
            begin
                // key byte reads zero
                s_d.rdata[fci_pkg::BIT_RAM_EN] = s_q.ram_en;
                s_d.rdata[fci_pkg::BIT_RAM_MODE] = s_q.ram_mode;
            end
        end

        if (wr_now)
        begin
            if (hit(wb_adr_i, fci_pkg::OFS_ERR_EN) && wb_sel_i[0])
            begin
                s_d.err_en = wb_dat_i[7:0] & fci_pkg::ERR_EN_MASK;
            end
            if (hit(wb_adr_i, fci_pkg::OFS_RDY_EN) && wb_sel_i[0])
            begin
                s_d.rdy_en = wb_dat_i[fci_pkg::BIT_RDY_EN];
            end
            // busy sequencer silently drops address writes
            if (hit(wb_adr_i, fci_pkg::OFS_START) && seq_i.sequencer_ready)
            begin
                s_d.start_addr = lane_merge(s_q.start_addr, wb_dat_i, wb_sel_i)
                                 & ~fci_pkg::ADDR_RO_MASK;
            end
            if (hit(wb_adr_i, fci_pkg::OFS_END) && seq_i.sequencer_ready)
            begin
                s_d.end_addr = lane_merge(s_q.end_addr, wb_dat_i, wb_sel_i)
                               & ~fci_pkg::ADDR_RO_MASK;
            end
            // only an exact low-halfword write with the key unlocks the bits
            if (hit(wb_adr_i, fci_pkg::OFS_RAM_EN) && wb_sel_i == fci_pkg::SEL_HALF_LOW
                && wb_dat_i[15:8] == fci_pkg::RAM_KEY)
            begin
                s_d.ram_en = wb_dat_i[fci_pkg::BIT_RAM_EN];
                s_d.ram_mode = wb_dat_i[fci_pkg::BIT_RAM_MODE];
            end
        end

        // init beats a concurrent address write
        if (init_wr)
        begin
            s_d.start_addr = 32'h00000000;
            s_d.end_addr = 32'h00000000;
        end

        // lock: set wins over release
        if (seq_i.lock_release && !viol)
        begin
            s_d.lock = 1'b0;
        end
        if (seq_i.lock_request || viol)
        begin
            s_d.lock = 1'b1;
        end
        if (seq_i.blank_check_start && bc_bad)
        begin
            s_d.lock = 1'b1;
        end

        s_d.err_irq = |(err_flags & s_q.err_en);
        s_d.rdy_prev = seq_i.sequencer_ready;
        s_d.rdy_irq = s_q.rdy_en & seq_i.sequencer_ready & ~s_q.rdy_prev;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_q <= fci_pkg::STATE_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign wb_dat_o = s_q.rdata;
    assign wb_ack_o = s_q.ack;
    assign command_lock_flag_o = s_q.lock;
    assign setup_init_o = init_wr;
    assign command_start_address_o = s_q.start_addr;
    assign command_end_address_o = s_q.end_addr;
    assign target_start_address_o = eff_start(s_q.start_addr, seq_i.cmd_kind,
                                              seq_i.large_block);
    assign target_end_address_o = bc_end;
    assign work_ram_access_enable_o = s_q.ram_en;
    assign work_ram_transfer_mode_o = s_q.ram_mode;
    // high-speed mode trades away reads for write bandwidth
    assign work_ram_read_allow_o = s_q.ram_en & ~s_q.ram_mode;
    assign work_ram_write_allow_o = s_q.ram_en;
    assign flash_error_irq_o = s_q.err_irq;
    assign ready_irq_o = s_q.rdy_irq;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_err_corrected: assert property (@(posedge clk_i) disable iff (rst_i)
        (seq_i.corrected_error_flag && s_q.err_en[fci_pkg::BIT_CORRECTED]) |=> flash_error_irq_o)
        else $error("corrected error did not raise error request");

    a_err_data_viol: assert property (@(posedge clk_i) disable iff (rst_i)
        (seq_i.data_violation_flag && s_q.err_en[fci_pkg::BIT_DATA_VIOL]) |=> flash_error_irq_o)
        else $error("data violation did not raise error request");

    a_err_lock: assert property (@(posedge clk_i) disable iff (rst_i)
        (command_lock_flag_o && s_q.err_en[fci_pkg::BIT_LOCK]) |=> flash_error_irq_o)
        else $error("command lock did not raise error request");

    a_err_code_viol: assert property (@(posedge clk_i) disable iff (rst_i)
        (seq_i.code_violation_flag && s_q.err_en[fci_pkg::BIT_CODE_VIOL]) |=> flash_error_irq_o)
        else $error("code violation did not raise error request");

    a_err_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.err_en == 8'h00) |=> !flash_error_irq_o)
        else $error("error request with all enables off");

    a_rdy_edge: assert property (@(posedge clk_i) disable iff (rst_i)
        ready_irq_o |-> $past(seq_i.sequencer_ready) && !$past(seq_i.sequencer_ready, 2))
        else $error("ready request without a rising ready");

    a_addr_busy: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_now && !seq_i.sequencer_ready && !init_wr) |=> $stable(s_q.start_addr)
        && $stable(s_q.end_addr))
        else $error("address changed while sequencer busy");

    a_addr_low: assert property (@(posedge clk_i) disable iff (rst_i)
        command_start_address_o[1:0] == 2'b00 && command_end_address_o[1:0] == 2'b00)
        else $error("read-only address bits not zero");

    a_init_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        init_wr |=> command_start_address_o == 32'h00000000
        && command_end_address_o == 32'h00000000)
        else $error("set-up init did not clear addresses");

    a_bc_lock: assert property (@(posedge clk_i) disable iff (rst_i)
        (seq_i.blank_check_start && bc_bad) |=> command_lock_flag_o)
        else $error("bad blank-check order did not lock");

    a_viol_lock: assert property (@(posedge clk_i) disable iff (rst_i)
        viol |=> command_lock_flag_o)
        else $error("violation did not lock");

    a_ram_key: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_now && hit(wb_adr_i, fci_pkg::OFS_RAM_EN) && wb_dat_i[15:8] != fci_pkg::RAM_KEY)
        |=> $stable(work_ram_access_enable_o) && $stable(work_ram_transfer_mode_o))
        else $error("work-ram bits changed without key");

    a_key_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o && !wb_we_i && hit(wb_adr_i, fci_pkg::OFS_RAM_EN) |-> wb_dat_o[31:2] == 30'h0)
        else $error("key byte read back nonzero");

    a_ram_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        !work_ram_access_enable_o |-> !work_ram_read_allow_o && !work_ram_write_allow_o)
        else $error("work ram open while disabled");

    a_ram_mode: assert property (@(posedge clk_i) disable iff (rst_i)
        work_ram_transfer_mode_o |-> !work_ram_read_allow_o)
        else $error("read allowed in high-speed mode");

    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle after request");

    a_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !req |=> !wb_ack_o)
        else $error("ack without request");

    a_rdy_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !s_q.rdy_en |=> !ready_irq_o)
        else $error("ready request while off");

    a_err_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        flash_error_irq_o |-> $past(s_q.err_en) != 8'h00)
        else $error("error request while off");

    a_addr_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_now |=> $stable(command_start_address_o) && $stable(command_end_address_o))
        else $error("address moved unwritten");

    a_ram_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_now |=> $stable(work_ram_access_enable_o) && $stable(work_ram_transfer_mode_o))
        else $error("work-ram bits moved");

    a_tgt_code: assert property (@(posedge clk_i) disable iff (rst_i)
        (seq_i.cmd_kind == fci_pkg::CMD_PROG_CODE || seq_i.cmd_kind == fci_pkg::CMD_ERASE_CODE)
        |-> target_start_address_o[31:24] == 8'h00)
        else $error("code target high bits");

    a_tgt_data: assert property (@(posedge clk_i) disable iff (rst_i)
        (seq_i.cmd_kind == fci_pkg::CMD_PROG_DATA || seq_i.cmd_kind == fci_pkg::CMD_ERASE_DATA)
        |-> target_start_address_o[31:19] == 13'h0000)
        else $error("data target high bits");

    a_tgt_page: assert property (@(posedge clk_i) disable iff (rst_i)
        seq_i.cmd_kind == fci_pkg::CMD_PROG_CODE |-> target_start_address_o[7:0] == 8'h00)
        else $error("program target off page");

    a_lock_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        command_lock_flag_o && !seq_i.lock_release |=> command_lock_flag_o)
        else $error("lock dropped unreleased");

    c_addr_write: cover property (@(posedge clk_i) disable iff (rst_i)
        wr_now && hit(wb_adr_i, fci_pkg::OFS_START) && seq_i.sequencer_ready);
    c_key_unlock: cover property (@(posedge clk_i) disable iff (rst_i)
        wr_now && hit(wb_adr_i, fci_pkg::OFS_RAM_EN) && wb_dat_i[15:8] == fci_pkg::RAM_KEY);
    c_rdy_irq: cover property (@(posedge clk_i) disable iff (rst_i) ready_irq_o);
    c_bc_lock: cover property (@(posedge clk_i) disable iff (rst_i)
        seq_i.blank_check_start && bc_bad);
    c_init_clear: cover property (@(posedge clk_i) disable iff (rst_i)
        init_wr);

endmodule // fci_regs
`default_nettype wire

// ===== rtl/fci_pkg.sv
// Functional notes
// - corrected-error enable b0 passes corrected-error flag onto flash error request
// - data-violation enable b3 passes data-flash violation flag onto flash error request
// - command-lock enable b4 passes command lock flag onto flash error request
// - code-violation enable b7 passes code-flash violation flag onto flash error request
// - ready enable b0 gives a ready request when ready rises from 0 to 1
// - start and end address writes land only while ready is 1
// - two lowest bits of both address registers are read-only zero
// - start address gives the first target address of area commands
// - start address bits below the command boundary are ignored
// - code-flash commands ignore start address bits 31 to 24
// - data-flash commands ignore start address bits 31 to 19
// - reset and setting the set-up init bit clear both address registers
// - end address gives blank-check end, bits 31 to 19 and 1:0 ignored
// - wrong blank-check address order puts the sequencer into command lock
// - work-ram enable b0 blocks (0) or permits (1) work-ram access
// - work-ram b1 selects normal access (0) or high-speed writes only (1)
// - work-ram bits change only on a 16-bit write carrying key c4
// - the key byte is never stored and reads as zero
// - any access violation flag sets command lock
// - ready is 0 while a sequencer command runs, 1 otherwise
`default_nettype none
package fci_pkg;

    // ----------------------------------------------------------------
    // register map, byte addresses
    // ----------------------------------------------------------------
    localparam logic [31:0] OFS_ERR_EN = 32'h007fe014;
    localparam logic [31:0] OFS_RDY_EN = 32'h007fe018;
    localparam logic [31:0] OFS_START = 32'h007fe030;
    localparam logic [31:0] OFS_END = 32'h007fe034;
    localparam logic [31:0] OFS_RAM_EN = 32'h007fe054;
    localparam logic [31:0] OFS_SETUP = 32'h007fe08c;

    // ----------------------------------------------------------------
    // fields, masks and reset values
    // ----------------------------------------------------------------
    localparam int BIT_CORRECTED = 0;
    localparam int BIT_DATA_VIOL = 3;
    localparam int BIT_LOCK = 4;
    localparam int BIT_CODE_VIOL = 7;
    localparam int BIT_RDY_EN = 0;
    localparam int BIT_RAM_EN = 0;
    localparam int BIT_RAM_MODE = 1;
    localparam int BIT_SETUP_INIT = 0;
    localparam logic [7:0] ERR_EN_MASK = 8'h99;
    localparam logic [7:0] ERR_EN_RESET = 8'h99;
    localparam logic [7:0] RAM_KEY = 8'hc4;
    localparam logic [3:0] SEL_HALF_LOW = 4'h3;
    localparam logic [31:0] ADDR_RO_MASK = 32'h00000003;
    localparam logic [31:0] CODE_AREA_MASK = 32'h00ffffff;
    localparam logic [31:0] DATA_AREA_MASK = 32'h0007ffff;
    localparam logic [31:0] BND_4 = 32'h00000003;
    localparam logic [31:0] BND_16 = 32'h0000000f;
    localparam logic [31:0] BND_64 = 32'h0000003f;
    localparam logic [31:0] BND_256 = 32'h000000ff;
    localparam logic [31:0] BND_8K = 32'h00001fff;
    localparam logic [31:0] BND_32K = 32'h00007fff;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [6:0] {
        CMD_PROG_CODE = 7'h01,
        CMD_PROG_DATA = 7'h02,
        CMD_ERASE_CODE = 7'h04,
        CMD_ERASE_DATA = 7'h08,
        CMD_BLANK = 7'h10,
        CMD_CONFIG = 7'h20,
        CMD_LOCKBIT = 7'h40
    } fci_cmd_t;

    typedef struct packed {
        logic sequencer_ready;
        logic corrected_error_flag;
        logic data_violation_flag;
        logic code_violation_flag;
        logic lock_request;
        logic lock_release;
        logic blank_check_start;
        logic blank_check_direction;
        fci_cmd_t cmd_kind;
        logic large_block;
    } fci_seq_t;

    typedef struct packed {
        logic [7:0] err_en;
        logic rdy_en;
        logic [31:0] start_addr;
        logic [31:0] end_addr;
        logic ram_en;
        logic ram_mode;
        logic lock;
        logic err_irq;
        logic rdy_irq;
        logic rdy_prev;
        logic ack;
        logic [31:0] rdata;
    } fci_state_t;

    localparam fci_state_t STATE_RESET = '{
        err_en: ERR_EN_RESET,
        rdy_en: 1'b0,
        start_addr: 32'h00000000,
        end_addr: 32'h00000000,
        ram_en: 1'b0,
        ram_mode: 1'b0,
        lock: 1'b0,
        err_irq: 1'b0,
        rdy_irq: 1'b0,
        rdy_prev: 1'b1,
        ack: 1'b0,
        rdata: 32'h00000000
    };

endpackage
`default_nettype wire

// ===== verification/test_fci_regs.sv
`timescale 1ns/10ps
`default_nettype none
module test_fci_regs;
    // ----------------------------------------------------------------
    // stimulus and design
    // ----------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [31:0] adr = 32'h00000000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h00000000;
    logic [31:0] rdata;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    fci_pkg::fci_seq_t seq = '{sequencer_ready: 1'b1, cmd_kind: fci_pkg::CMD_PROG_CODE, default: 1'b0};
    logic lock;
    logic [31:0] tgt_start;
    logic [31:0] tgt_end;
    logic ram_en;
    logic ram_mode;
    logic rd_allow;
    logic wr_allow;
    logic err_irq;
    logic rdy_irq;
    logic [31:0] raw_start;
    logic [31:0] raw_end;
    logic init_pulse;
    int inits = 0;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    int i;
    int bits[4] = '{0, 3, 4, 7};

    fci_regs i_fci_regs (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .seq_i(seq), .command_lock_flag_o(lock), .setup_init_o(init_pulse),
        .command_start_address_o(raw_start), .command_end_address_o(raw_end),
        .target_start_address_o(tgt_start), .target_end_address_o(tgt_end),
        .work_ram_access_enable_o(ram_en), .work_ram_transfer_mode_o(ram_mode),
        .work_ram_read_allow_o(rd_allow), .work_ram_write_allow_o(wr_allow),
        .flash_error_irq_o(err_irq), .ready_irq_o(rdy_irq)
    );

    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // hangs are cut short here; the whole run needs well under 2000 cycles
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        inits <= inits + (init_pulse === 1'b1);
        if (cycles > 5000)
        begin
            fails++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one classic cycle; waits for ack, takes data at that same edge
    task automatic bus(input logic w, input logic [31:0] a, input logic [3:0] s,
                       input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rdata = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, 4'hf, d);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 4'hf, 32'h00000000);
        chk(rdata, exp);
    endtask

    // lets n edges land, then looks at settled outputs
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic clear_causes();
        @(posedge clk_i);
        seq.corrected_error_flag <= 1'b0;
        seq.data_violation_flag <= 1'b0;
        seq.code_violation_flag <= 1'b0;
        seq.lock_request <= 1'b0;
        seq.blank_check_start <= 1'b0;
        seq.lock_release <= 1'b1;
        @(posedge clk_i);
        seq.lock_release <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(fci_pkg::OFS_ERR_EN, 32'h00000099);
        rd_chk(fci_pkg::OFS_RDY_EN, 32'h00000000);
        rd_chk(fci_pkg::OFS_START, 32'h00000000);
        rd_chk(fci_pkg::OFS_END, 32'h00000000);
        rd_chk(fci_pkg::OFS_RAM_EN, 32'h00000000);
        rd_chk(32'h007fe100, 32'h00000000);
        wr(fci_pkg::OFS_ERR_EN, 32'h000000ff);
        rd_chk(fci_pkg::OFS_ERR_EN, 32'h00000099);
        wr(fci_pkg::OFS_RDY_EN, 32'h000000ff);
        rd_chk(fci_pkg::OFS_RDY_EN, 32'h00000001);
        // each error cause alone, passed on and then masked
        for (i = 0; i < 4; i++)
        begin
            wr(fci_pkg::OFS_ERR_EN, 32'h00000001 << bits[i]);
            @(posedge clk_i);
            case (bits[i])
                0: seq.corrected_error_flag <= 1'b1;
                3: seq.data_violation_flag <= 1'b1;
                4: seq.lock_request <= 1'b1;
                default: seq.code_violation_flag <= 1'b1;
            endcase
            settle(3);
            chk(err_irq, 1'b1);
            chk(lock, (bits[i] != 0));
            wr(fci_pkg::OFS_ERR_EN, 32'h00000000);
            settle(2);
            chk(err_irq, 1'b0);
            clear_causes();
            settle(2);
            chk(lock, 1'b0);
        end
        // ready rising gives one pulse
        @(posedge clk_i);
        seq.sequencer_ready <= 1'b0;
        settle(2);
        chk(rdy_irq, 1'b0);
        wr(fci_pkg::OFS_START, 32'h12345678);
        rd_chk(fci_pkg::OFS_START, 32'h00000000);
        wr(fci_pkg::OFS_END, 32'h12345678);
        rd_chk(fci_pkg::OFS_END, 32'h00000000);
        @(posedge clk_i);
        seq.sequencer_ready <= 1'b1;
        @(posedge clk_i);
        @(negedge clk_i);
        chk(rdy_irq, 1'b1);
        @(negedge clk_i);
        chk(rdy_irq, 1'b0);
        // address registers and the masked target views
        wr(fci_pkg::OFS_START, 32'hffffffff);
        rd_chk(fci_pkg::OFS_START, 32'hfffffffc);
        wr(fci_pkg::OFS_END, 32'hffffffff);
        rd_chk(fci_pkg::OFS_END, 32'hfffffffc);
        settle(1);
        chk(raw_start, 32'hfffffffc);
        chk(raw_end, 32'hfffffffc);
        chk(tgt_start, 32'h00ffff00);
        chk(tgt_end, 32'h0007fffc);
        @(posedge clk_i);
        seq.cmd_kind <= fci_pkg::CMD_PROG_DATA;
        settle(1);
        chk(tgt_start, 32'h0007fffc);
        @(posedge clk_i);
        seq.cmd_kind <= fci_pkg::CMD_ERASE_DATA;
        settle(1);
        chk(tgt_start, 32'h0007ffc0);
        @(posedge clk_i);
        seq.cmd_kind <= fci_pkg::CMD_CONFIG;
        settle(1);
        chk(tgt_start, 32'h0007fff0);
        @(posedge clk_i);
        seq.cmd_kind <= fci_pkg::CMD_ERASE_CODE;
        seq.large_block <= 1'b1;
        settle(1);
        chk(tgt_start, 32'h00ff8000);
        @(posedge clk_i);
        seq.cmd_kind <= fci_pkg::CMD_LOCKBIT;
        seq.large_block <= 1'b0;
        settle(1);
        chk(tgt_start, 32'h00ffe000);
        wr(fci_pkg::OFS_SETUP, 32'h00000001);
        chk(inits, 32'h00000001);
        rd_chk(fci_pkg::OFS_START, 32'h00000000);
        rd_chk(fci_pkg::OFS_END, 32'h00000000);
        // blank check in wrong and right order
        wr(fci_pkg::OFS_START, 32'h00000100);
        wr(fci_pkg::OFS_END, 32'h00000040);
        @(posedge clk_i);
        seq.cmd_kind <= fci_pkg::CMD_BLANK;
        seq.blank_check_direction <= 1'b0;
        seq.blank_check_start <= 1'b1;
        @(posedge clk_i);
        seq.blank_check_start <= 1'b0;
        settle(1);
        chk(lock, 1'b1);
        clear_causes();
        seq.blank_check_direction <= 1'b1;
        seq.blank_check_start <= 1'b1;
        @(posedge clk_i);
        seq.blank_check_start <= 1'b0;
        settle(2);
        chk(lock, 1'b0);
        wr(fci_pkg::OFS_END, 32'h00000200);
        seq.blank_check_direction <= 1'b0;
        seq.blank_check_start <= 1'b1;
        @(posedge clk_i);
        seq.blank_check_start <= 1'b0;
        settle(2);
        chk(lock, 1'b0);
        // work ram enable behind the key
        bus(1'b1, fci_pkg::OFS_RAM_EN, 4'h3, 32'h0000c4ff);
        rd_chk(fci_pkg::OFS_RAM_EN, 32'h00000003);
        settle(0);
        chk({ram_en, ram_mode, rd_allow, wr_allow}, 32'h0000000d);
        bus(1'b1, fci_pkg::OFS_RAM_EN, 4'h3, 32'h0000c300);
        rd_chk(fci_pkg::OFS_RAM_EN, 32'h00000003);
        wr(fci_pkg::OFS_RAM_EN, 32'h0000c400);
        rd_chk(fci_pkg::OFS_RAM_EN, 32'h00000003);
        bus(1'b1, fci_pkg::OFS_RAM_EN, 4'h3, 32'h0000c401);
        rd_chk(fci_pkg::OFS_RAM_EN, 32'h00000001);
        settle(0);
        chk({ram_en, ram_mode, rd_allow, wr_allow}, 32'h0000000b);
        finish_test();
    end
endmodule // test_fci_regs
`default_nettype wire
